// [logic/rms_pkg.sv]
// Constants and types shared by the relay multiplexer sequencer.
package rms_pkg;

  localparam int CLK_HZ     = 10_000_000;
  localparam int US_PER_SEC = 1_000_000;

  // Relay delay step and settle pulse widths, in microseconds.
  localparam int STEP_US     = 100;
  localparam int PW_SHORT_US = 1;
  localparam int PW_DFLT_US  = 100;
  localparam int PW_LONG_US  = 1000;
  localparam int STEP_CYC     = STEP_US * (CLK_HZ / US_PER_SEC);
  localparam int PW_SHORT_CYC = PW_SHORT_US * (CLK_HZ / US_PER_SEC);
  localparam int PW_DFLT_CYC  = PW_DFLT_US * (CLK_HZ / US_PER_SEC);
  localparam int PW_LONG_CYC  = PW_LONG_US * (CLK_HZ / US_PER_SEC);

  // Count snapshot refresh period, in minutes.
  localparam longint REFRESH_MIN = 11;
  localparam longint REFRESH_CYC = REFRESH_MIN * 60 * longint'(CLK_HZ);

  // Register byte offsets.
  localparam logic [7:0] OFS_CMD      = 8'h00;
  localparam logic [7:0] OFS_CFG      = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_STATE_A  = 8'h0C;
  localparam logic [7:0] OFS_STATE_B  = 8'h10;
  localparam logic [7:0] OFS_STATE_D  = 8'h14;
  localparam logic [7:0] OFS_DIAG     = 8'h20;
  localparam logic [7:0] OFS_DIAG_END = 8'h34;
  localparam logic [7:0] OFS_CNT      = 8'h40;
  localparam logic [7:0] OFS_CNT_END  = 8'hB4;

  // Command word fields.
  localparam int CMD_CH_LSB   = 0;
  localparam int CMD_BANK_LSB = 4;
  localparam int CMD_MODE_LSB = 6;
  localparam int CMD_SIN_BIT  = 8;
  localparam int CMD_SOUT_BIT = 9;

  // Configuration word fields.
  localparam int CFG_ON_LSB    = 0;
  localparam int CFG_OFF_LSB   = 8;
  localparam int CFG_DBBM_BIT  = 16;
  localparam int CFG_GATE_BIT  = 17;
  localparam int CFG_EDGE_BIT  = 18;
  localparam int CFG_POL_BIT   = 19;
  localparam int CFG_OMODE_LSB = 24;
  localparam int CFG_PW_LSB    = 28;
  localparam logic [31:0] CFG_RESET = 32'h0001_0000;

  // Status word bit positions.
  localparam int ST_SYNC_BIT  = 0;
  localparam int ST_READY_BIT = 1;
  localparam int ST_WAIT_BIT  = 2;
  localparam int ST_BUSY_BIT  = 3;
  localparam int ST_OVR_BIT   = 16;
  localparam int ST_NEWD_BIT  = 17;

  localparam int          NUM_RELAYS = 30;
  localparam int          BANK_SIZE  = 13;
  localparam logic [3:0]  LAST_CH    = 4'hC;
  localparam logic [2:0]  DIAG_STAT  = 3'h4;
  localparam logic [2:0]  DIAG_TIME  = 3'h5;

  // Bank selection codes.
  localparam logic [1:0] BANK_NONE            = 2'h0;
  localparam logic [1:0] BANK_FIRST           = 2'h1;
  localparam logic [1:0] BANK_SECOND          = 2'h2;
  localparam logic [1:0] both_bank_select_code = 2'h3;

  // Meter modes.
  localparam logic [1:0] voltage_measure_mode = 2'h0;
  localparam logic [1:0] MODE_CURRENT         = 2'h1;
  localparam logic [1:0] MODE_RES2            = 2'h2;
  localparam logic [1:0] MODE_RES4            = 2'h3;

  // Settle output modes.
  localparam logic [2:0] OUT_LOW        = 3'h0;
  localparam logic [2:0] OUT_HIGH       = 3'h1;
  localparam logic [2:0] OUT_PULSE_HI   = 3'h2;
  localparam logic [2:0] OUT_PULSE_LO   = 3'h3;
  localparam logic [2:0] OUT_READY_HI   = 3'h4;
  localparam logic [2:0] OUT_READY_LO   = 3'h5;

  typedef enum logic [3:0] {
    RMS_IDLE  = 4'h1,
    RMS_GATE  = 4'h2,
    RMS_BREAK = 4'h4,
    RMS_MAKE  = 4'h8
  } rms_state_t;

endpackage : rms_pkg

// [logic/rms_timer.sv]
// Down-counting delay timer that pulses done after the loaded number of cycles.
`timescale 1ns/1ps
module rms_timer (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        start,
  input  wire logic [19:0] load,
  output logic             running,
  output logic             done
);

  typedef struct packed {
    logic [19:0] cnt;
    logic        run;
    logic        done;
  } rms_tmr_t;

  rms_tmr_t r_ff;
  rms_tmr_t nxt_r;

  always_comb begin
    nxt_r      = r_ff;
    nxt_r.done = 1'b0;
    if (start) begin
      nxt_r.cnt = load;
      nxt_r.run = 1'b1;
    end else if (r_ff.run) begin
      if (r_ff.cnt <= 20'h0_0001) begin
        nxt_r.run  = 1'b0;
        nxt_r.done = 1'b1;
      end else begin
        nxt_r.cnt = r_ff.cnt - 20'h0_0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign running = r_ff.run;
  assign done    = r_ff.done;

endmodule : rms_timer

// [logic/rms_sequencer.sv]
// Relay multiplexer sequencer with APB registers, break-before-make and counters.
//
// Notes on behaviour
// - Bank code 0 none, 1 first bank, 2 second bank, 3 both banks.
// - Break-before-make keeps at most one input channel on the meter.
// - Relay state reads as a bit per relay, 1 closed, 0 open.
// - Status bit 17 is set while unread converter data exists.
// - Status bit 16 flags a relay write arriving while busy.
// - Status bit 3 is high while the switching machine runs a command.
// - Status bit 2 is high while waiting for gating input or settling.
// - Status bit 1 is high once relays are settled and ready.
// - Status bit 0 mirrors the sampled gating input pin.
// - All other status bits are reserved and read as zero.
// - Energisation counts are kept and snapshots refresh every eleven minutes.
// - Thirty counters: first bank 0-12, second bank 0-12, routing 1-4.
// - Diagnostic channels 0-2 supplies, 3 temperature, 4 status, 5 timestamp.
// - Two-wire voltage on the second bank closes routing relays 1 and 2.
// - Each write in idle opens the bank relays, and routing relays if config bit 16 is set, waits the off-delay, then closes new ones.
// - Delays span 100 us to 25.6 ms in 100 us steps.
// - With gating enabled a write waits for the chosen edge or level.
// - Settle pulse width defaults to 100 us; 1 us or 1 ms selectable.
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
module rms_sequencer #(
  parameter logic [32:0] REFRESH_CYCLES = 33'(rms_pkg::REFRESH_CYC),
  parameter logic [19:0] PW_LONG_CYCLES = 20'(rms_pkg::PW_LONG_CYC)
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sync_in,
  output logic             sync_out,
  input  wire logic        conv_done,
  input  wire logic [1:0]  conv_chan,
  input  wire logic [15:0] conv_data,
  output logic [12:0]      relay_a,
  output logic [12:0]      relay_b,
  output logic [3:0]       relay_d
);

  typedef struct packed {
    rms_pkg::rms_state_t              st;
    logic [12:0]                      na;
    logic [12:0]                      nb;
    logic [3:0]                       nd;
    logic                             sout;
    logic [12:0]                      ra;
    logic [12:0]                      rb;
    logic [3:0]                       rd;
    logic                             ready;
    logic                             ovr;
    logic                             newd;
    logic [31:0]                      cfg;
    logic                             sin_q;
    logic                             sin_prev;
    logic [3:0][15:0]                 adc;
    logic [31:0]                      tstamp;
    logic [32:0]                      rfr;
    logic [rms_pkg::NUM_RELAYS-1:0][31:0] cnt;
    logic [rms_pkg::NUM_RELAYS-1:0][31:0] snap;
    logic                             sync_out;
    logic [31:0]                      prdata;
    logic                             pready;
    logic                             pslverr;
  } rms_regs_t;

  rms_regs_t r_ff;
  rms_regs_t nxt_r;

  logic                             t_start;
  logic [19:0]                      t_load;
  logic                             t_done;
  logic                             p_start;
  logic [19:0]                      p_load;
  logic                             p_run;
  logic [rms_pkg::NUM_RELAYS-1:0]   closed_now;
  logic [rms_pkg::NUM_RELAYS-1:0]   closed_nxt;
  logic [rms_pkg::NUM_RELAYS-1:0][31:0] cnt_inc;

  rms_timer u_delay (
    .clk     (clk),
    .rstn    (rstn),
    .start   (t_start),
    .load    (t_load),
    .running (),
    .done    (t_done)
  );

  rms_timer u_pulse (
    .clk     (clk),
    .rstn    (rstn),
    .start   (p_start),
    .load    (p_load),
    .running (p_run),
    .done    ()
  );

  // Counter order: first bank 0-12, second bank 0-12, routing relays 1-4.
  assign closed_now = {r_ff.rd, r_ff.rb, r_ff.ra};
  assign closed_nxt = {nxt_r.rd, nxt_r.rb, nxt_r.ra};

  genvar gi;
  generate
    for (gi = 0; gi < rms_pkg::NUM_RELAYS; gi++) begin : g_cnt
      assign cnt_inc[gi] = r_ff.cnt[gi] + {31'h0, closed_nxt[gi] & ~closed_now[gi]};
    end
  endgenerate

  // Delays are programmed as steps minus one, so 0 gives 100 us and 255 gives 25.6 ms.
  function automatic logic [19:0] rms_delay(input logic [7:0] steps);
    rms_delay = 20'((32'(steps) + 32'd1) * 32'(rms_pkg::STEP_CYC));
  endfunction : rms_delay

  logic        setup;
  logic        acc_wr;
  logic        acc_rd;
  logic        gate_hit;
  logic        edge_hit;
  logic        pol;
  logic [2:0]  omode;
  logic [2:0]  diag_idx;
  logic [5:0]  cnt_idx;
  logic [31:0] status;
  logic [3:0]  ch;
  logic [1:0]  bank;
  logic [1:0]  mode;
  logic        in_range;

  always_comb begin
    nxt_r    = r_ff;
    t_start  = 1'b0;
    t_load   = rms_delay(r_ff.cfg[rms_pkg::CFG_OFF_LSB +: 8]);
    p_start  = 1'b0;
    p_load   = 20'(rms_pkg::PW_DFLT_CYC);
    setup    = psel & ~penable;
    acc_wr   = psel & penable & r_ff.pready & pwrite;
    acc_rd   = psel & penable & r_ff.pready & ~pwrite;
    pol      = r_ff.cfg[rms_pkg::CFG_POL_BIT];
    omode    = r_ff.cfg[rms_pkg::CFG_OMODE_LSB +: 3];
    diag_idx = 3'((paddr - rms_pkg::OFS_DIAG) >> 2);
    cnt_idx  = 6'((paddr - rms_pkg::OFS_CNT) >> 2);
    ch       = pwdata[rms_pkg::CMD_CH_LSB +: 4];
    bank     = pwdata[rms_pkg::CMD_BANK_LSB +: 2];
    mode     = pwdata[rms_pkg::CMD_MODE_LSB +: 2];
    in_range = (ch <= rms_pkg::LAST_CH);

    // Pins are synchronous to clk, so one stage suffices for the mirror bit.
    nxt_r.sin_q    = sync_in;
    nxt_r.sin_prev = r_ff.sin_q;
    nxt_r.tstamp   = r_ff.tstamp + 32'h0000_0001;
    edge_hit = pol ? (r_ff.sin_q & ~r_ff.sin_prev) : (~r_ff.sin_q & r_ff.sin_prev);
    gate_hit = r_ff.cfg[rms_pkg::CFG_EDGE_BIT] ? edge_hit : (r_ff.sin_q == pol);

    status = '0;
    status[rms_pkg::ST_SYNC_BIT]  = r_ff.sin_q;
    status[rms_pkg::ST_READY_BIT] = r_ff.ready;
    status[rms_pkg::ST_WAIT_BIT]  = (r_ff.st == rms_pkg::RMS_GATE) || (r_ff.st == rms_pkg::RMS_MAKE);
    status[rms_pkg::ST_BUSY_BIT]  = (r_ff.st != rms_pkg::RMS_IDLE);
    status[rms_pkg::ST_OVR_BIT]   = r_ff.ovr;
    status[rms_pkg::ST_NEWD_BIT]  = r_ff.newd;

    // Read side effects come first so that a same-cycle event wins below.
    if (acc_rd) begin
      if (paddr == rms_pkg::OFS_STATUS) begin
        nxt_r.ovr = 1'b0;
      end else if (paddr >= rms_pkg::OFS_DIAG && paddr <= rms_pkg::OFS_DIAG_END && paddr[1:0] == 2'h0) begin
        nxt_r.newd = 1'b0;
        if (diag_idx == rms_pkg::DIAG_STAT) begin
          nxt_r.ovr = 1'b0;
        end
      end
    end

    if (conv_done) begin
      nxt_r.adc[conv_chan] = conv_data;
      nxt_r.newd           = 1'b1;
    end

    if (acc_wr && paddr == rms_pkg::OFS_CFG) begin
      nxt_r.cfg = pwdata;
    end

    case (r_ff.st)
      rms_pkg::RMS_IDLE: begin
        if (acc_wr && paddr == rms_pkg::OFS_CMD) begin
          nxt_r.na = '0;
          nxt_r.nb = '0;
          nxt_r.nd = '0;
          if (in_range && (bank == rms_pkg::BANK_FIRST || bank == rms_pkg::both_bank_select_code)) begin
            nxt_r.na[ch] = 1'b1;
          end
          if (in_range && (bank == rms_pkg::BANK_SECOND || bank == rms_pkg::both_bank_select_code)) begin
            nxt_r.nb[ch] = 1'b1;
          end
          if (bank != rms_pkg::BANK_NONE) begin
            if (mode == rms_pkg::MODE_CURRENT) begin
              nxt_r.nd = 4'h4;
            end else if (bank == rms_pkg::both_bank_select_code || mode == rms_pkg::MODE_RES4) begin
              nxt_r.nd = 4'hA;
            end else if (bank == rms_pkg::BANK_SECOND) begin
              nxt_r.nd = 4'h3;
            end else begin
              nxt_r.nd = 4'h2;
            end
          end
          nxt_r.sout  = pwdata[rms_pkg::CMD_SOUT_BIT];
          nxt_r.ready = 1'b0;
          if (r_ff.cfg[rms_pkg::CFG_GATE_BIT] | pwdata[rms_pkg::CMD_SIN_BIT]) begin
            nxt_r.st = rms_pkg::RMS_GATE;
          end else begin
            nxt_r.st = rms_pkg::RMS_BREAK;
            t_start  = 1'b1;
          end
        end
      end
      rms_pkg::RMS_GATE: begin
        if (gate_hit) begin
          nxt_r.st = rms_pkg::RMS_BREAK;
          t_start  = 1'b1;
        end
      end
      rms_pkg::RMS_BREAK: begin
        if (t_done) begin
          nxt_r.st = rms_pkg::RMS_MAKE;
          nxt_r.ra = r_ff.na;
          nxt_r.rb = r_ff.nb;
          nxt_r.rd = r_ff.nd;
          t_start  = 1'b1;
          t_load   = rms_delay(r_ff.cfg[rms_pkg::CFG_ON_LSB +: 8]);
        end
      end
      rms_pkg::RMS_MAKE: begin
        if (t_done) begin
          nxt_r.st    = rms_pkg::RMS_IDLE;
          nxt_r.ready = 1'b1;
          p_start     = r_ff.sout;
        end
      end
      default: begin
        nxt_r.st = rms_pkg::RMS_IDLE;
      end
    endcase

    // Bank relays open on the first break cycle; routing relays open too if DBBM is set or a gated command changes them.
    if (t_start && nxt_r.st == rms_pkg::RMS_BREAK) begin
      nxt_r.ra = '0;
      nxt_r.rb = '0;
      if (r_ff.cfg[rms_pkg::CFG_DBBM_BIT] || r_ff.nd != r_ff.rd) begin
        nxt_r.rd = '0;
      end
    end

    // A command write that lands while busy is dropped so the running sequence is not torn.
    if (acc_wr && paddr == rms_pkg::OFS_CMD && r_ff.st != rms_pkg::RMS_IDLE) begin
      nxt_r.ovr = 1'b1;
    end

    case (r_ff.cfg[rms_pkg::CFG_PW_LSB +: 2])
      2'h1:    p_load = 20'(rms_pkg::PW_SHORT_CYC);
      2'h2:    p_load = PW_LONG_CYCLES;
      default: p_load = 20'(rms_pkg::PW_DFLT_CYC);
    endcase

    // The pulse follows the timer's run flag alone, so its width is exactly the loaded count.
    case (omode)
      rms_pkg::OUT_HIGH:     nxt_r.sync_out = 1'b1;
      rms_pkg::OUT_PULSE_HI: nxt_r.sync_out = p_run;
      rms_pkg::OUT_PULSE_LO: nxt_r.sync_out = ~p_run;
      rms_pkg::OUT_READY_HI: nxt_r.sync_out = nxt_r.ready;
      rms_pkg::OUT_READY_LO: nxt_r.sync_out = ~nxt_r.ready;
      default:               nxt_r.sync_out = 1'b0;
    endcase

    nxt_r.cnt = cnt_inc;
    if (r_ff.rfr >= REFRESH_CYCLES - 33'h0_0000_0001) begin
      nxt_r.rfr  = '0;
      nxt_r.snap = cnt_inc;
    end else begin
      nxt_r.rfr = r_ff.rfr + 33'h0_0000_0001;
    end

    // The slave answers in the first access cycle: data is latched during setup.
    nxt_r.pready  = setup;
    nxt_r.pslverr = 1'b0;
    if (setup) begin
      nxt_r.prdata  = '0;
      if (paddr == rms_pkg::OFS_CMD) begin
        nxt_r.prdata = 32'({r_ff.sout, 9'h000});
      end else if (paddr == rms_pkg::OFS_CFG) begin
        nxt_r.prdata = r_ff.cfg;
      end else if (paddr == rms_pkg::OFS_STATUS) begin
        nxt_r.prdata = status;
      end else if (paddr == rms_pkg::OFS_STATE_A) begin
        nxt_r.prdata = 32'(r_ff.ra);
      end else if (paddr == rms_pkg::OFS_STATE_B) begin
        nxt_r.prdata = 32'(r_ff.rb);
      end else if (paddr == rms_pkg::OFS_STATE_D) begin
        nxt_r.prdata = 32'({r_ff.rd, 1'b0});
      end else if (paddr >= rms_pkg::OFS_DIAG && paddr <= rms_pkg::OFS_DIAG_END && paddr[1:0] == 2'h0) begin
        if (diag_idx == rms_pkg::DIAG_STAT) begin
          nxt_r.prdata = status;
        end else if (diag_idx == rms_pkg::DIAG_TIME) begin
          nxt_r.prdata = r_ff.tstamp;
        end else begin
          nxt_r.prdata = 32'(r_ff.adc[diag_idx[1:0]]);
        end
      end else if (paddr >= rms_pkg::OFS_CNT && paddr <= rms_pkg::OFS_CNT_END && paddr[1:0] == 2'h0) begin
        nxt_r.prdata = r_ff.snap[cnt_idx];
      end else begin
        nxt_r.pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_ff     <= '0;
      r_ff.st  <= rms_pkg::RMS_IDLE;
      r_ff.cfg <= rms_pkg::CFG_RESET;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign prdata   = r_ff.prdata;
  assign pready   = r_ff.pready;
  assign pslverr  = r_ff.pslverr;
  assign sync_out = r_ff.sync_out;
  assign relay_a  = r_ff.ra;
  assign relay_b  = r_ff.rb;
  assign relay_d  = r_ff.rd;

endmodule : rms_sequencer

// [tb/rms_sequencer_asserts.sv]
// Concurrent checks on the relay sequencer ports.
`timescale 1ns/1ps
module rms_sequencer_asserts #(
  parameter logic [32:0] REFRESH_CYCLES = 33'(rms_pkg::REFRESH_CYC),
  parameter logic [19:0] PW_LONG_CYCLES = 20'(rms_pkg::PW_LONG_CYC)
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sync_in,
  input wire logic        sync_out,
  input wire logic [12:0] relay_a,
  input wire logic [12:0] relay_b,
  input wire logic [3:0]  relay_d
);
  logic [15:0] zero_cnt_ff;
  logic [15:0] nxt_zero_cnt;
  logic        rd_en;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  assign rd_en = pready && psel && penable && !pwrite;
  // Counts how long both banks have been fully open, to judge the break time.
  always_comb begin
    nxt_zero_cnt = zero_cnt_ff;
    if ((relay_a != 13'h0000) || (relay_b != 13'h0000)) nxt_zero_cnt = 16'h0000;
    else if (zero_cnt_ff != 16'hFFFF) nxt_zero_cnt = zero_cnt_ff + 16'h0001;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) zero_cnt_ff <= 16'h0000;
    else zero_cnt_ff <= nxt_zero_cnt;
  end
  a_setup_answer: assert property (psel && !penable |=> pready) else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("bad error answer");
  a_one_channel: assert property ($onehot0(relay_a) && $onehot0(relay_b) &&
    (relay_a == 13'h0000 || relay_b == 13'h0000 || relay_a == relay_b)) else $error("two channels closed");
  a_break_first: assert property ($changed({relay_a, relay_b}) && {relay_a, relay_b} != 26'h0
    |-> $past({relay_a, relay_b}) == 26'h0) else $error("relays switched without break");
  a_break_hold: assert property ($rose(|{relay_a, relay_b}) |-> zero_cnt_ff >= 16'h03E7)
    else $error("break shorter than the off delay");
  a_sync_mirror: assert property (rd_en && paddr == rms_pkg::OFS_STATUS
    |-> prdata[0] == $past(sync_in, 2)) else $error("status bit 0 not gating input");
  a_reserved_zero: assert property (rd_en && paddr == rms_pkg::OFS_STATUS
    |-> prdata[15:4] == 12'h000 && prdata[31:18] == 14'h0000) else $error("reserved status bits set");
  a_ready_busy: assert property (rd_en && paddr == rms_pkg::OFS_STATUS
    |-> !(prdata[1] && prdata[3])) else $error("ready while busy");
  a_state_b: assert property (rd_en && paddr == rms_pkg::OFS_STATE_B
    |-> prdata == {19'h0_0000, $past(relay_b)}) else $error("bank b state mismatch");
  a_state_d: assert property (rd_en && paddr == rms_pkg::OFS_STATE_D
    |-> prdata == {27'h000_0000, $past(relay_d), 1'b0}) else $error("routing state mismatch");
endmodule : rms_sequencer_asserts
bind rms_sequencer rms_sequencer_asserts #(.REFRESH_CYCLES(REFRESH_CYCLES), .PW_LONG_CYCLES(PW_LONG_CYCLES))
  u_chk (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_in(sync_in), .sync_out(sync_out),
  .relay_a(relay_a), .relay_b(relay_b), .relay_d(relay_d));

// [tb/rms_conv_model.sv]
// Behavioural diagnostic converter that answers one request per pulse.
`timescale 1ns/1ps
module rms_conv_model (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        req,
  input wire logic [1:0]  req_chan,
  input wire logic [15:0] req_data,
  output logic            conv_done,
  output logic [1:0]      conv_chan,
  output logic [15:0]     conv_data
);
  // Outside the done pulse the bus toggles so that stale data never looks valid.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      conv_done <= 1'b0;
      conv_chan <= 2'h0;
      conv_data <= 16'h0000;
    end else if (req) begin
      conv_done <= 1'b1;
      conv_chan <= req_chan;
      conv_data <= req_data;
    end else begin
      conv_done <= 1'b0;
      conv_chan <= ~conv_chan;
      conv_data <= ~conv_data;
    end
  end
endmodule : rms_conv_model

// [tb/tb.sv]
// Register-level testbench for the relay multiplexer sequencer.
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sync_in = 1'b0;
  logic        sync_out;
  logic        conv_done;
  logic [1:0]  conv_chan;
  logic [15:0] conv_data;
  logic [12:0] relay_a;
  logic [12:0] relay_b;
  logic [3:0]  relay_d;
  logic        req = 1'b0;
  logic [31:0] rd;
  logic        er;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          so_cnt = 0;
  logic [12:0] ea [4] = '{13'h0000, 13'h0020, 13'h0000, 13'h0020};
  logic [12:0] eb [4] = '{13'h0000, 13'h0000, 13'h0020, 13'h0020};
  logic [3:0]  ed [4] = '{4'h0, 4'h2, 4'h3, 4'hA};
  always #50 clk = ~clk;
  always @(posedge clk) if (sync_out === 1'b1) so_cnt <= so_cnt + 1;
  rms_sequencer #(.REFRESH_CYCLES(33'h0_0000_00C8), .PW_LONG_CYCLES(20'h0_0032)) uut (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_in(sync_in),
    .sync_out(sync_out), .conv_done(conv_done), .conv_chan(conv_chan), .conv_data(conv_data),
    .relay_a(relay_a), .relay_b(relay_b), .relay_d(relay_d));
  rms_conv_model u_conv (.clk(clk), .rstn(rstn), .req(req), .req_chan(2'h3), .req_data(16'h1234),
    .conv_done(conv_done), .conv_chan(conv_chan), .conv_data(conv_data));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic st();
    apb(1'b0, rms_pkg::OFS_STATUS, 32'h0000_0000);
  endtask : st
  // Polls until the switching machine has left its busy state.
  task automatic idle();
    do begin
      st();
    end while (rd[3] !== 1'b0);
  endtask : idle
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  initial begin
    #4_000_000;
    miscompares++;
    results();
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, rms_pkg::OFS_CFG, 32'h0000_0000);
    chk("cfg reset", rd, rms_pkg::CFG_RESET);
    st();
    chk("status reset", rd & 32'h0003_000D, 32'h0000_0000);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk("unmapped err", {31'h0, er}, 32'h0000_0001);
    $display("test reset done");
    apb(1'b1, rms_pkg::OFS_CMD, 32'h0000_002C);
    st();
    chk("busy", {31'h0, rd[3]}, 32'h0000_0001);
    apb(1'b1, rms_pkg::OFS_CMD, 32'h0000_0015);
    st();
    chk("overrun", {31'h0, rd[16]}, 32'h0000_0001);
    st();
    chk("overrun clear", {31'h0, rd[16]}, 32'h0000_0000);
    idle();
    chk("ready", rd & 32'h0000_000E, 32'h0000_0002);
    chk("late write dropped", {19'h0, relay_a}, 32'h0000_0000);
    chk("second bank", {19'h0, relay_b}, 32'h0000_1000);
    chk("routing", {28'h0, relay_d}, 32'h0000_0003);
    apb(1'b0, rms_pkg::OFS_STATE_B, 32'h0000_0000);
    chk("state b", rd, 32'h0000_1000);
    apb(1'b0, rms_pkg::OFS_STATE_D, 32'h0000_0000);
    chk("state d", rd, 32'h0000_0006);
    $display("test overrun done");
    for (int b = 0; b < 4; b++) begin
      apb(1'b1, rms_pkg::OFS_CMD, {26'h0, 2'(b), 4'h5});
      idle();
      chk("bank a", {19'h0, relay_a}, {19'h0, ea[b]});
      chk("bank b", {19'h0, relay_b}, {19'h0, eb[b]});
      chk("bank d", {28'h0, relay_d}, {28'h0, ed[b]});
    end
    $display("test banks done");
    apb(1'b1, rms_pkg::OFS_CFG, 32'h120B_0000);
    apb(1'b1, rms_pkg::OFS_CMD, 32'h0000_0217);
    repeat (50) @(posedge clk);
    st();
    chk("waiting", rd & 32'h0000_0005, 32'h0000_0004);
    chk("held", {19'h0, relay_b}, 32'h0000_0020);
    sync_in <= 1'b1;
    idle();
    chk("gated switch", {19'h0, relay_a}, 32'h0000_0080);
    chk("sync level", {31'h0, rd[0]}, 32'h0000_0001);
    repeat (30) @(posedge clk);
    chk("pulse width", so_cnt, rms_pkg::PW_SHORT_CYC);
    apb(1'b1, rms_pkg::OFS_CFG, rms_pkg::CFG_RESET);
    sync_in <= 1'b0;
    $display("test gating done");
    @(posedge clk);
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    repeat (5) @(posedge clk);
    st();
    chk("new data", {31'h0, rd[17]}, 32'h0000_0001);
    apb(1'b0, 8'h2C, 32'h0000_0000);
    chk("temperature", rd, 32'h0000_1234);
    apb(1'b0, 8'h30, 32'h0000_0000);
    chk("status channel", rd & 32'h0003_000F, 32'h0000_0002);
    $display("test diagnostics done");
    repeat (450) @(posedge clk);
    apb(1'b0, 8'hA4, 32'h0000_0000);
    chk("count b12", rd, 32'h0000_0001);
    apb(1'b0, 8'hA8, 32'h0000_0000);
    chk("count d1", rd, 32'h0000_0002);
    apb(1'b0, 8'hB4, 32'h0000_0000);
    chk("count d4", rd, 32'h0000_0001);
    $display("test counts done");
    results();
  end
endmodule : tb
